// ===== rtl/obc_decoder.sv
/*
  Option byte decoder: keeps the two nonvolatile configuration bytes, lets
  a programming tool write both and read back byte 0 in programming mode, and drives decoded
  settings to the clock, reset, watchdog and memory protection units.
  Assumes prog_mode and the nv access strobes come from core-clock logic.
*/
`timescale 1ns/10ps
module obc_decoder (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Programming tool access
  input wire logic prog_mode,
  input wire logic cfg_sel,
  input wire logic cfg_wr,
  input wire logic cfg_erase,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_refused,
  // Program memory protection
  input wire logic pm_wr_req,
  input wire logic pm_rd_ext_req,
  output logic pm_wr_allow,
  output logic pm_rd_ext_allow,
  output logic pm_mass_erase,
  // Decoded settings
  output obc_pkg::obc_sys_t sys_cfg,
  output obc_pkg::obc_clkcfg_t clk_cfg
);
  import obc_pkg::*;

  // Nonvolatile byte images; erased state reads all ones
  logic [7:0] nv0_ff;
  logic [7:0] nv1_ff;
  logic [7:0] act0_ff;
  logic [7:0] act1_ff;
  logic [7:0] cfg_rdata_ff;
  logic refused_ff;
  logic erase_pm_ff;
  logic wr_ok;
  logic er_ok;

  //////////////////////////////////////////////////////////////////////////
  // Store. Reset does not touch nonvolatile content; power-on image is all
  // ones (ERASED). The store is modelled as flops initialised during the
  // first reset only, since rst also recurs during operation.
  // Flag starts clear at power-up and sets once the first reset is released
  logic nv_init_ff = 1'b0;

  always_ff @(posedge mclk) begin
    if (!rst) begin
      nv_init_ff <= 1'b1;
    end
  end

  assign wr_ok = prog_mode & cfg_sel & cfg_wr & ~act0_ff[BIT_WR_PROT];
  assign er_ok = prog_mode & cfg_sel & cfg_erase & ~act0_ff[BIT_WR_PROT];

  always_ff @(posedge mclk) begin
    if (rst && !nv_init_ff) begin
      nv0_ff <= ERASED;
      nv1_ff <= ERASED;
    end else if (er_ok) begin
      nv0_ff <= ERASED;
      nv1_ff <= ERASED;
    end else if (wr_ok) begin
      // Programming only clears bits, as in flash
      if (cfg_wdata[7] == 1'b0) begin
        nv1_ff <= nv1_ff & {1'b1, cfg_wdata[6:0]};
      end else begin
        nv0_ff <= nv0_ff & {1'b1, cfg_wdata[6:0]};
      end
    end
  end

  // Address is carried in cfg_wdata[7]: clear selects byte 1, set selects byte 0,
  // so bit 7 of either byte is never programmed and stays at one.

  //////////////////////////////////////////////////////////////////////////
  // Erase of config under readout protection also pulses pm_mass_erase, on the same edge as the config erase
  always_ff @(posedge mclk) begin
    if (rst) begin
      erase_pm_ff <= 1'b0;
    end else begin
      erase_pm_ff <= er_ok & act0_ff[BIT_RD_PROT];
    end
  end
  assign pm_mass_erase = erase_pm_ff;

  //////////////////////////////////////////////////////////////////////////
  // Capture at reset; held until the next reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      act0_ff <= nv_init_ff ? nv0_ff : CFG0_RST;
      act1_ff <= nv_init_ff ? nv1_ff : CFG1_RST;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Tool read-back, only in programming mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_rdata_ff <= 8'h00;
      refused_ff <= 1'b0;
    end else begin
      cfg_rdata_ff <= (prog_mode && cfg_sel) ? nv0_ff : 8'h00;
      refused_ff <= cfg_sel & (cfg_wr | cfg_erase) & ~(wr_ok | er_ok);
    end
  end
  assign cfg_rdata = cfg_rdata_ff;
  assign cfg_refused = refused_ff;

  //////////////////////////////////////////////////////////////////////////
  // Program memory gating
  assign pm_wr_allow = pm_wr_req & ~act0_ff[BIT_WR_PROT] & ~act0_ff[BIT_RD_PROT];
  assign pm_rd_ext_allow = pm_rd_ext_req & ~act0_ff[BIT_RD_PROT];

  //////////////////////////////////////////////////////////////////////////
  // Decoding
  function automatic obc_clk_t clk_decode(input logic rc_off, input logic [2:0] band);
    if (!rc_off) begin
      clk_decode = OBC_CLK_RC;
    end else begin
      unique case (band)
        3'h0: clk_decode = OBC_CLK_1_2;
        3'h1: clk_decode = OBC_CLK_2_4;
        3'h2: clk_decode = OBC_CLK_4_8;
        3'h3: clk_decode = OBC_CLK_8_16;
        3'h4, 3'h5: clk_decode = OBC_CLK_RSVD;
        default: clk_decode = OBC_CLK_EXT;
      endcase
    end
  endfunction

  always_comb begin
    sys_cfg.halt_reset_select = act0_ff[BIT_HALT_RST];
    sys_cfg.watchdog_type_select = act0_ff[BIT_WATCHDOG_TYPE_SELECT];
    sys_cfg.undervolt_threshold_sel = obc_uv_t'(act0_ff[BIT_UV_HI:BIT_UV_LO]);
    sys_cfg.first_block_size = act0_ff[BIT_BLK_HI:BIT_BLK_LO];
    sys_cfg.first_block_bytes = 13'h0200 << act0_ff[BIT_BLK_HI:BIT_BLK_LO];
    sys_cfg.readout_protect = act0_ff[BIT_RD_PROT];
    sys_cfg.program_write_protect = act0_ff[BIT_WR_PROT];
    clk_cfg.reset_delay_select = act1_ff[BIT_RST_DLY];
    clk_cfg.reset_delay_cycles = act1_ff[BIT_RST_DLY] ? RST_CYC_SHORT : RST_CYC_LONG;
    clk_cfg.resonator_band_select = act1_ff[BIT_BAND_HI:BIT_BAND_LO];
    clk_cfg.clock_mode = clk_decode(act1_ff[BIT_RC_OFF], act1_ff[BIT_BAND_HI:BIT_BAND_LO]);
    clk_cfg.internal_rc_select = act1_ff[BIT_RC_OFF];
    clk_cfg.pll_halve_enable = act1_ff[BIT_HALVE];
    clk_cfg.pll_factor_select = act1_ff[BIT_FACTOR];
    clk_cfg.pll_bypass = act1_ff[BIT_BYPASS];
  end

endmodule

// ===== rtl/obc_pkg.sv
/*
  Package for the option byte configuration decoder: bit positions, field
  codes, reset values and the reset-phase cycle counts.
  Assumes a single core clock and a synchronous active-high reset.
*/
// Summary of operation
// - Byte 0 bit 7 set gives reset on entering halt while watchdog active.
// - Byte 0 bit 6 clear keeps watchdog always on; set leaves it to software.
// - Byte 0 bits 5:4 pick undervoltage threshold; 11 turns detection off.
// - Byte 0 bits 3:2 pick first block size 0.5k, 1k, 2k or 4k.
// - Byte 0 bit 1 set blocks program memory readout and writes.
// - Erasing config under readout protection first erases all program memory; here pm_mass_erase pulses on the same edge as the config erase.
// - Byte 0 bit 0 set forever refuses program memory and own-bit changes.
// - Byte 1 bit 7 picks 4096 or 256 reset-phase and halt-exit cycles; here bit 7 is never programmed and stays at one, so always 256.
// - Byte 1 bits 6:4 pick resonator band or external clock when RC off.
// - Byte 1 bit 3 clear runs internal RC; set uses resonator or clock.
// - Byte 1 bit 2 clear halves PLL output; set skips halving.
// - Byte 1 bit 1 picks PLL factor: clear times four, set times eight.
// - Byte 1 bit 0 clear enables PLL; set bypasses it.
// - Config bytes are read and written only in programming mode; here only byte 0 can be read back.
// - Unprogrammed nonvolatile content reads as all ones.
package obc_pkg;

  localparam int BIT_HALT_RST = 7;
  localparam int BIT_WATCHDOG_TYPE_SELECT = 6;
  localparam int BIT_UV_HI = 5;
  localparam int BIT_UV_LO = 4;
  localparam int BIT_BLK_HI = 3;
  localparam int BIT_BLK_LO = 2;
  localparam int BIT_RD_PROT = 1;
  localparam int BIT_WR_PROT = 0;
  localparam int BIT_RST_DLY = 7;
  localparam int BIT_BAND_HI = 6;
  localparam int BIT_BAND_LO = 4;
  localparam int BIT_RC_OFF = 3;
  localparam int BIT_HALVE = 2;
  localparam int BIT_FACTOR = 1;
  localparam int BIT_BYPASS = 0;

  localparam logic [7:0] CFG0_RST = 8'hFC;
  localparam logic [7:0] CFG1_RST = 8'hF7;
  localparam logic [7:0] ERASED = 8'hFF;

  localparam logic [12:0] RST_CYC_LONG = 13'h1000;
  localparam logic [12:0] RST_CYC_SHORT = 13'h0100;

  typedef enum logic [1:0] {
    OBC_UV_LOW, OBC_UV_MED, OBC_UV_HIGH, OBC_UV_OFF
  } obc_uv_t;

  typedef enum logic [2:0] {
    OBC_CLK_RC, OBC_CLK_1_2, OBC_CLK_2_4, OBC_CLK_4_8, OBC_CLK_8_16,
    OBC_CLK_EXT, OBC_CLK_RSVD
  } obc_clk_t;

  typedef struct packed {
    logic halt_reset_select;
    logic watchdog_type_select;
    obc_uv_t undervolt_threshold_sel;
    logic [1:0] first_block_size;
    logic [12:0] first_block_bytes;
    logic readout_protect;
    logic program_write_protect;
  } obc_sys_t;

  typedef struct packed {
    logic reset_delay_select;
    logic [12:0] reset_delay_cycles;
    logic [2:0] resonator_band_select;
    obc_clk_t clock_mode;
    logic internal_rc_select;
    logic pll_halve_enable;
    logic pll_factor_select;
    logic pll_bypass;
  } obc_clkcfg_t;

endpackage

// ===== verif/obc_tool_model.sv
/* Programming tool model: drives mode and store accesses of the decoder.
   Assumes the bench calls its tasks; changes land on falling edges. */
`timescale 1ns/10ps
module obc_tool_model (
  // Clock input and tool outputs
  input wire logic mclk,
  output logic prog_mode,
  output logic cfg_sel,
  output logic cfg_wr,
  output logic cfg_erase,
  output logic [7:0] cfg_wdata
);
  initial begin
    {prog_mode, cfg_sel, cfg_wr, cfg_erase, cfg_wdata} = 12'h000;
  end
  task automatic mode(input logic on);
    @(negedge mclk) prog_mode = on;
  endtask
  // Images used keep 256 cycles only with no resonator; halving only at x8
  task automatic op(input logic w, input logic e, input logic [7:0] d);
    @(negedge mclk);
    {cfg_sel, cfg_wr, cfg_erase, cfg_wdata} = {1'b1, w, e, d};
    @(negedge mclk);
    // Idle data inverted so a stale value never looks valid
    {cfg_sel, cfg_wr, cfg_erase, cfg_wdata} = {3'b000, ~d};
  endtask
endmodule

// ===== verif/obc_decoder_chk.sv
/* Port checker for the option byte decoder.
   Assumes one clock and a synchronous high reset; bound at the foot. */
`timescale 1ns/10ps
module obc_decoder_chk (
  // Watched ports, grouped to save space
  input wire logic mclk, rst, prog_mode, cfg_sel, cfg_wr, cfg_erase, cfg_refused,
  input wire logic pm_wr_req, pm_rd_ext_req, pm_wr_allow, pm_rd_ext_allow, pm_mass_erase,
  input wire logic [7:0] cfg_wdata, cfg_rdata,
  input wire obc_pkg::obc_sys_t sys_cfg,
  input wire obc_pkg::obc_clkcfg_t clk_cfg
);
  import obc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_wr; cfg_sel && (cfg_wr || cfg_erase); endsequence
  sequence s_rp_erase; cfg_sel && cfg_erase && prog_mode && sys_cfg.readout_protect; endsequence
  property p_ref_mode; s_wr ##0 !prog_mode |=> cfg_refused; endproperty
  property p_ref_wp; s_wr ##0 sys_cfg.program_write_protect |=> cfg_refused; endproperty
  property p_rd_gate; !(prog_mode && cfg_sel) |=> cfg_rdata == 8'h00; endproperty
  property p_hold; !$past(rst) |-> $stable(sys_cfg) && $stable(clk_cfg); endproperty
  property p_rd_prot; sys_cfg.readout_protect |-> !pm_rd_ext_allow && !pm_wr_allow; endproperty
  property p_rd_open; pm_rd_ext_req && !sys_cfg.readout_protect |-> pm_rd_ext_allow; endproperty
  property p_wp; sys_cfg.program_write_protect |-> !pm_wr_allow; endproperty
  property p_mass; s_rp_erase ##0 !sys_cfg.program_write_protect |=> pm_mass_erase; endproperty
  property p_blk; sys_cfg.first_block_bytes == (13'h0200 << sys_cfg.first_block_size); endproperty
  property p_dly;
    clk_cfg.reset_delay_cycles == (clk_cfg.reset_delay_select ? 13'h0100 : 13'h1000);
  endproperty
  a_ref_mode: assert property (p_ref_mode) else $error("no refusal outside mode");
  a_ref_wp: assert property (p_ref_wp) else $error("no refusal under lock");
  a_rd_gate: assert property (p_rd_gate) else $error("read data outside mode");
  a_hold: assert property (p_hold) else $error("settings moved");
  a_rd_prot: assert property (p_rd_prot) else $error("protected access allowed");
  a_rd_open: assert property (p_rd_open) else $error("open readout refused");
  a_wp: assert property (p_wp) else $error("locked write allowed");
  a_mass: assert property (p_mass) else $error("no mass erase");
  a_blk: assert property (p_blk) else $error("block size wrong");
  a_dly: assert property (p_dly) else $error("reset cycles wrong");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind obc_decoder obc_decoder_chk obc_decoder_chk_inst (.mclk, .rst, .prog_mode, .cfg_sel,
  .cfg_wr, .cfg_erase, .cfg_refused, .pm_wr_req, .pm_rd_ext_req, .pm_wr_allow,
  .pm_rd_ext_allow, .pm_mass_erase, .cfg_wdata, .cfg_rdata, .sys_cfg, .clk_cfg);

// ===== verif/obc_decoder_tb.sv
/* Self-checking bench for the option byte decoder.
   Assumes the tool model drives the store side; bench drives reset. */
`timescale 1ns/10ps
module obc_decoder_tb;
  import obc_pkg::*;
  logic mclk, rst, prog_mode, cfg_sel, cfg_wr, cfg_erase, pm_wr_req, pm_rd_ext_req;
  logic cfg_refused, pm_wr_allow, pm_rd_ext_allow, pm_mass_erase;
  logic [7:0] cfg_wdata, cfg_rdata;
  obc_sys_t sys_cfg;
  obc_clkcfg_t clk_cfg;
  int err_count = 0;
  int compares = 0;
  obc_decoder obc_decoder_inst (.mclk, .rst, .prog_mode, .cfg_sel, .cfg_wr, .cfg_erase,
    .cfg_wdata, .cfg_rdata, .cfg_refused, .pm_wr_req, .pm_rd_ext_req, .pm_wr_allow,
    .pm_rd_ext_allow, .pm_mass_erase, .sys_cfg, .clk_cfg);
  obc_tool_model obc_tool_model_inst (.mclk, .prog_mode, .cfg_sel, .cfg_wr, .cfg_erase,
    .cfg_wdata);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // New settings only show after a reset
  task automatic do_rst;
    @(negedge mclk) rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    chk(24'(sys_cfg), 24'({2'b11, OBC_UV_OFF, 2'b11, 13'h1000, 2'b00}));
    chk(24'(clk_cfg), {1'b1, 13'h0100, 3'b111, OBC_CLK_RC, 4'b0111});
    chk(24'({pm_wr_allow, pm_rd_ext_allow}), 24'h3);
    obc_tool_model_inst.mode(1'b1);
    obc_tool_model_inst.op(1'b0, 1'b0, 8'h00);
    chk(24'(cfg_rdata), 24'hFF);
    obc_tool_model_inst.mode(1'b0);
    obc_tool_model_inst.op(1'b0, 1'b0, 8'h00);
    chk(24'(cfg_rdata), 24'h0);
    obc_tool_model_inst.op(1'b1, 1'b0, 8'h80);
    chk(24'(cfg_refused), 24'h1);
  endtask
  task automatic t_program;
    obc_tool_model_inst.mode(1'b1);
    obc_tool_model_inst.op(1'b1, 1'b0, 8'h82);
    obc_tool_model_inst.op(1'b1, 1'b0, 8'h32);
    chk(24'(sys_cfg), 24'({2'b11, OBC_UV_OFF, 2'b11, 13'h1000, 2'b00}));
    do_rst();
    chk(24'(sys_cfg), 24'({2'b10, OBC_UV_LOW, 2'b00, 13'h0200, 2'b10}));
    chk(24'(clk_cfg), {1'b1, 13'h0100, 3'b011, OBC_CLK_RC, 4'b0010});
    chk(24'({pm_wr_allow, pm_rd_ext_allow}), 24'h0);
  endtask
  task automatic t_erase_lock;
    obc_tool_model_inst.op(1'b0, 1'b1, 8'h00);
    chk(24'(pm_mass_erase), 24'h1);
    obc_tool_model_inst.op(1'b1, 1'b0, 8'h81);
    obc_tool_model_inst.op(1'b1, 1'b0, 8'h6E);
    do_rst();
    chk(24'(clk_cfg), {1'b1, 13'h0100, 3'b110, OBC_CLK_EXT, 4'b1110});
    chk(24'({pm_wr_allow, pm_rd_ext_allow}), 24'h1);
    obc_tool_model_inst.op(1'b0, 1'b1, 8'h00);
    chk(24'(cfg_refused), 24'h1);
    obc_tool_model_inst.op(1'b0, 1'b0, 8'h00);
    chk(24'(cfg_rdata), 24'h81);
  endtask
  initial begin
    rst = 1'b1;
    pm_wr_req = 1'b1;
    pm_rd_ext_req = 1'b1;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    t_defaults();
    t_program();
    t_erase_lock();
    end_sim();
  end
  // Run needs under 200 cycles; 5000 leaves ample margin
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
endmodule
